// *** core/pss_regs.svh ***
/*
 * register offsets, field positions, reset values and timing counts
 * of the supply supervisor; assumes a 10 MHz system clock
 */
`ifndef PSS_REGS_SVH
`define PSS_REGS_SVH
// ****************************
// offsets
// ****************************
`define PSS_ST_A        8'h00
`define PSS_ST_B        8'h02
`define PSS_ST_C        8'h30
`define PSS_ST_D        8'h40
`define PSS_ST_E        8'h50
`define PSS_ST_F        8'ha0
`define PSS_ST_G        8'ha6
`define PSS_ST_H        8'he5
`define PSS_CTRL        8'h01
`define PSS_MASK        8'h03
`define PSS_FLAGS       8'h04
`define PSS_LINK        8'h05
`define PSS_EXT         8'h06
// ****************************
// reset values and fields
// ****************************
`define PSS_CTRL_RST    8'h00
`define PSS_MASK_RST    8'hff
`define PSS_LINK_RST    8'h1f
`define PSS_EXT_RST     8'h00
`define PSS_B_SEN       0
`define PSS_B_SSEL      1
`define PSS_B_SREQ      2
`define PSS_B_FDIS      3
`define PSS_B_DLY       4
`define PSS_B_XDLY      5
`define PSS_B_XPP       6
`define PSS_B_XP34      7
`define PSS_I2C_ADDR    7'h25
// ****************************
// timing
// ****************************
`define PSS_CLK_NS      100
`define PSS_TICK_NS     500000
`define PSS_TICK_CYC    (`PSS_TICK_NS / `PSS_CLK_NS)
`define PSS_FOFF_NS     100000000
`define PSS_FOFF_TICKS  (`PSS_FOFF_NS / `PSS_TICK_NS)
`define PSS_XDLY_NS     2500000
`define PSS_XDLY_TICKS  (`PSS_XDLY_NS / `PSS_TICK_NS)
`define PSS_RMIN_NS     20000000
`define PSS_RMIN_TICKS  (`PSS_RMIN_NS / `PSS_TICK_NS)
`define PSS_LDO_NS      16000
`define PSS_LDO_CYC     ((`PSS_LDO_NS + `PSS_CLK_NS - 1) / `PSS_CLK_NS)
`define PSS_BUCK_CYC    16
`endif

// *** core/pss_pkg.sv ***
/*
 * types of the supply supervisor
 * assumes nothing of its surroundings
 */
`default_nettype none
package pss_pkg;
    typedef enum logic [2:0] {
        I_IDLE  = 3'b000,
        I_ADDR  = 3'b001,
        I_ACKA  = 3'b010,
        I_WR    = 3'b011,
        I_ACKW  = 3'b100,
        I_RD    = 3'b101,
        I_ACKR  = 3'b110
    } pss_i2c_e;
    typedef enum logic {
        F_RUN   = 1'b0,
        F_OFF   = 1'b1
    } pss_fault_e;
endpackage
`default_nettype wire

// *** core/pss_sync.sv ***
/*
 * two-flop synchroniser for a vector of levels
 * assumes each bit is an independent level
 */
`default_nettype none
module pss_sync #(
    parameter int W = 1
) (
    input  wire logic         clk_sys_in,
    input  wire logic         rst_n_in,
    input  wire logic [W-1:0] d_in,
    output var  logic [W-1:0] q_out
);
    logic [W-1:0] meta;
    always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            meta  <= '0;
            q_out <= '0;
        end else begin
            meta  <= d_in;
            q_out <= meta;
        end
    end
endmodule
`default_nettype wire

// *** core/pss_supervisor.sv ***
/*
 * supply supervisor: scaling select, fault flags, interrupt, reset,
 * external enable, output fault retry and i2c register slave
 * assumes comparators and pins are levels, switch_cycle is a level toggle per cycle
 */
// Contract
// - bucks go to scaled setpoint while scaling trigger active, else primary.
// - scaling is only a setpoint choice, no state change.
// - register scaling off when scaling enable bit is zero.
// - enable 1, source 0: request bit turns scaling on and off.
// - enable 1, source 1: scaled in sleep, request bit ignored.
// - never scaled while in deep sleep.
// - i2c alive above lockout; outputs off until above monitor threshold.
// - below monitor raises interrupt and drops reset, outputs stay on; below lockout turns outputs off.
// - input low status live; its interrupt has its own mask.
// - flags always live; mask gates only the latched fault bit.
// - unmasked fault latches; any latched bit pulls interrupt low.
// - host read clears a bit only once its cause has gone.
// - eight read-to-clear status addresses.
// - interrupt sources: temp, input ov/uv, output uv/ov, current limits.
// - sources masked after reset; software unmasks over i2c.
// - interrupt pin is open drain, pulls low only.
// - reset drops at once on input window loss or linked pok loss.
// - reset releases after 20ms to 100ms programmed delay.
// - external enable source selectable: pok, sleep control, gp pin.
// - pins 1/2 allow 2.5ms delay and push-pull; pins 3/4 not.
// - external power good can trigger regulator startup.
// - output uv/ov turns all outputs off 100ms then restarts.
// - retry repeats until fault clears; disable bit suppresses it.
`default_nettype none
`include "pss_regs.svh"
module pss_supervisor import pss_pkg::*; #(
    parameter int TICK_CYCLES = `PSS_TICK_CYC
) (
    input  wire logic       clk_sys_in,
    input  wire logic       rst_n_in,
    input  wire logic       i2c_scl_in,
    input  wire logic       i2c_sda_in,
    output var  logic       i2c_sda_out,
    output var  logic       i2c_sda_oe_n_out,
    input  wire logic       above_lockout_in,
    input  wire logic       below_monitor_in,
    input  wire logic       above_overvoltage_in,
    input  wire logic       temp_warning_in,
    input  wire logic [4:0] output_uv_in,
    input  wire logic [4:0] output_ov_in,
    input  wire logic [2:0] buck_current_limit_in,
    input  wire logic [1:0] ldo_current_limit_in,
    input  wire logic       switch_cycle_in,
    input  wire logic       soft_start_done_in,
    input  wire logic [4:0] regulator_power_ok_in,
    input  wire logic       external_power_good_in,
    input  wire logic       scaling_pin_in,
    input  wire logic       sleep_state_in,
    input  wire logic       deep_sleep_state_in,
    input  wire logic       gp_trigger_in,
    output var  logic       scaling_active_out,
    output var  logic       outputs_enable_out,
    output var  logic       startup_trigger_out,
    output var  logic       system_reset_n_out,
    output var  logic       interrupt_n_out,
    output var  logic       interrupt_oe_n_out,
    output var  logic       external_supply_enable_out,
    output var  logic       external_supply_enable_oe_n_out
);
    // ****************************
    // input synchronisers
    // ****************************
    logic [32:0] raw;
    logic [32:0] syn;
    logic        scl_s, sda_s, lock_s, mon_s, ovp_s, temp_s, sw_s, ss_s;
    logic        epg_s, pin_s, slp_s, dsl_s, gp_s;
    logic [4:0]  uv_s, ov_s, pok_s;
    logic [2:0]  buck_s;
    logic [1:0]  ldo_s;
    assign raw = {i2c_scl_in, i2c_sda_in, above_lockout_in, below_monitor_in,
                  above_overvoltage_in, temp_warning_in, output_uv_in, output_ov_in,
                  buck_current_limit_in, ldo_current_limit_in, switch_cycle_in,
                  soft_start_done_in, regulator_power_ok_in, external_power_good_in,
                  scaling_pin_in, sleep_state_in, deep_sleep_state_in, gp_trigger_in};
    pss_sync #(.W(33)) u_sync (
        .clk_sys_in (clk_sys_in),
        .rst_n_in   (rst_n_in),
        .d_in       (raw),
        .q_out      (syn)
    );
    assign {scl_s, sda_s, lock_s, mon_s, ovp_s, temp_s, uv_s, ov_s, buck_s, ldo_s,
            sw_s, ss_s, pok_s, epg_s, pin_s, slp_s, dsl_s, gp_s} = syn;

    // ****************************
    // registers and prescaler
    // ****************************
    logic [7:0]  ctrl, mask, link, ext;
    logic [7:0]  fault_lat, live;
    logic        wr_stb, rc_stb;
    logic [7:0]  wr_ptr, wr_data;
    logic [15:0] pre_cnt;
    logic        tick;
    always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            ctrl <= `PSS_CTRL_RST;
            mask <= `PSS_MASK_RST;
            link <= `PSS_LINK_RST;
            ext  <= `PSS_EXT_RST;
        end else if (wr_stb) begin
            if (wr_ptr == `PSS_CTRL) begin
                ctrl <= wr_data;
            end else if (wr_ptr == `PSS_MASK) begin
                mask <= wr_data;
            end else if (wr_ptr == `PSS_LINK) begin
                link <= wr_data;
            end else if (wr_ptr == `PSS_EXT) begin
                ext <= wr_data;
            end
        end
    end
    always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            pre_cnt <= 16'h0000;
            tick    <= 1'b0;
        end else if (pre_cnt == 16'(TICK_CYCLES - 1)) begin
            pre_cnt <= 16'h0000;
            tick    <= 1'b1;
        end else begin
            pre_cnt <= pre_cnt + 16'h0001;
            tick    <= 1'b0;
        end
    end

    // ****************************
    // fault flags and interrupt
    // ****************************
    logic       sw_q;
    logic [4:0] buck_cnt;
    logic [7:0] ldo_cnt;
    always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            sw_q     <= 1'b0;
            buck_cnt <= 5'h00;
            ldo_cnt  <= 8'h00;
        end else begin
            sw_q <= sw_s;
            if (!(|buck_s)) begin
                buck_cnt <= 5'h00;
            end else if (sw_s && !sw_q && buck_cnt != 5'(`PSS_BUCK_CYC)) begin
                buck_cnt <= buck_cnt + 5'h01;
            end
            if (!(|ldo_s)) begin
                ldo_cnt <= 8'h00;
            end else if (ldo_cnt != 8'(`PSS_LDO_CYC)) begin
                ldo_cnt <= ldo_cnt + 8'h01;
            end
        end
    end
    assign live = {1'b0,
                   ss_s && ldo_cnt == 8'(`PSS_LDO_CYC),
                   ss_s && buck_cnt == 5'(`PSS_BUCK_CYC),
                   |ov_s, ss_s && (|uv_s), temp_s, ovp_s, mon_s};
    always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            fault_lat <= 8'h00;
        end else begin
            // clear only gone causes, set wins
            fault_lat <= (fault_lat & ~({8{rc_stb}} & ~live)) | (live & ~mask);
        end
    end
    always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            interrupt_n_out    <= 1'b0;
            interrupt_oe_n_out <= 1'b1;
        end else begin
            interrupt_n_out    <= 1'b0;
            interrupt_oe_n_out <= ~(|fault_lat);
        end
    end

    // ****************************
    // input gating and fault retry
    // ****************************
    logic       mon_ok;
    pss_fault_e fstate;
    logic [7:0] foff_cnt;
    always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            mon_ok <= 1'b0;
        end else if (!lock_s) begin
            mon_ok <= 1'b0;
        end else if (!mon_s) begin
            mon_ok <= 1'b1;
        end
    end
    always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            fstate   <= F_RUN;
            foff_cnt <= 8'h00;
        end else begin
            case (fstate)
                F_RUN: begin
                    foff_cnt <= 8'h00;
                    if (mon_ok && !ctrl[`PSS_B_FDIS] && (|ov_s || (ss_s && |uv_s))) begin
                        fstate <= F_OFF;
                    end
                end
                F_OFF: begin
                    if (!lock_s) begin
                        fstate <= F_RUN;
                    end else if (tick) begin
                        if (foff_cnt == 8'(`PSS_FOFF_TICKS - 1)) begin
                            fstate <= F_RUN;
                        end else begin
                            foff_cnt <= foff_cnt + 8'h01;
                        end
                    end
                end
                default: fstate <= F_RUN;
            endcase
        end
    end
    always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            outputs_enable_out  <= 1'b0;
            startup_trigger_out <= 1'b0;
            scaling_active_out  <= 1'b0;
        end else begin
            outputs_enable_out  <= mon_ok && lock_s && fstate == F_RUN;
            startup_trigger_out <= epg_s && mon_ok && lock_s && fstate == F_RUN;
            scaling_active_out  <= !dsl_s && (pin_s || (ctrl[`PSS_B_SEN] &&
                (ctrl[`PSS_B_SSEL] ? slp_s : ctrl[`PSS_B_SREQ])));
        end
    end

    // ****************************
    // system reset
    // ****************************
    logic       rst_ok;
    logic [7:0] rst_cnt, rst_target;
    logic [2:0] dly_code;
    assign rst_ok = lock_s && !mon_s && !ovp_s && outputs_enable_out &&
                    (&(pok_s | ~link[4:0]));
    assign dly_code = (ctrl[6:4] > 3'h4) ? 3'h4 : ctrl[6:4];
    assign rst_target = 8'(`PSS_RMIN_TICKS * (dly_code + 3'h1));
    always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            rst_cnt            <= 8'h00;
            system_reset_n_out <= 1'b0;
        end else if (!rst_ok) begin
            rst_cnt            <= 8'h00;
            system_reset_n_out <= 1'b0;
        end else if (rst_cnt == rst_target) begin
            system_reset_n_out <= 1'b1;
        end else if (tick) begin
            rst_cnt <= rst_cnt + 8'h01;
        end
    end

    // ****************************
    // external supply enable
    // ****************************
    logic       ext_src, ext_lvl;
    logic [2:0] ext_cnt;
    always_comb begin
        case (ext[4:3])
            2'b00:   ext_src = pok_s[ext[2:0] > 3'h4 ? 3'h4 : ext[2:0]];
            2'b01:   ext_src = !slp_s && !dsl_s;
            default: ext_src = gp_s;
        endcase
    end
    always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            ext_lvl <= 1'b0;
            ext_cnt <= 3'h0;
        end else if (!ext_src) begin
            ext_lvl <= 1'b0;
            ext_cnt <= 3'h0;
        end else if (!ext[`PSS_B_XDLY] || ext[`PSS_B_XP34]) begin
            ext_lvl <= 1'b1;
        end else if (ext_cnt == 3'(`PSS_XDLY_TICKS)) begin
            ext_lvl <= 1'b1;
        end else if (tick) begin
            ext_cnt <= ext_cnt + 3'h1;
        end
    end
    always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            external_supply_enable_out      <= 1'b0;
            external_supply_enable_oe_n_out <= 1'b1;
        end else if (ext[`PSS_B_XPP] && !ext[`PSS_B_XP34]) begin
            external_supply_enable_out      <= ext_lvl;
            external_supply_enable_oe_n_out <= 1'b0;
        end else begin
            external_supply_enable_out      <= 1'b0;
            external_supply_enable_oe_n_out <= ext_lvl;
        end
    end

    // ****************************
    // i2c slave
    // ****************************
    pss_i2c_e   ist;
    logic       scl_q, sda_q, rw, first;
    logic [3:0] bcnt;
    logic [7:0] sh, tx, ptr, rdata;
    logic       is_st;
    wire        st_cond = scl_s && scl_q && sda_q && !sda_s;
    wire        sp_cond = scl_s && scl_q && !sda_q && sda_s;
    wire        rise = scl_s && !scl_q;
    wire        fall = !scl_s && scl_q;
    assign is_st = ptr == `PSS_ST_A || ptr == `PSS_ST_B || ptr == `PSS_ST_C ||
                   ptr == `PSS_ST_D || ptr == `PSS_ST_E || ptr == `PSS_ST_F ||
                   ptr == `PSS_ST_G || ptr == `PSS_ST_H;
    always_comb begin
        if (ptr == `PSS_ST_A) begin
            rdata = fault_lat;
        end else if (ptr == `PSS_CTRL) begin
            rdata = ctrl;
        end else if (ptr == `PSS_MASK) begin
            rdata = mask;
        end else if (ptr == `PSS_FLAGS) begin
            rdata = live;
        end else if (ptr == `PSS_LINK) begin
            rdata = link;
        end else if (ptr == `PSS_EXT) begin
            rdata = ext;
        end else begin
            rdata = 8'h00;
        end
    end
    always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            ist <= I_IDLE; scl_q <= 1'b1; sda_q <= 1'b1; rw <= 1'b0; first <= 1'b0;
            bcnt <= 4'h0; sh <= 8'h00; tx <= 8'h00; ptr <= 8'h00; wr_ptr <= 8'h00;
            wr_data <= 8'h00; wr_stb <= 1'b0; rc_stb <= 1'b0;
            i2c_sda_out <= 1'b0; i2c_sda_oe_n_out <= 1'b1;
        end else begin
            scl_q  <= scl_s;
            sda_q  <= sda_s;
            wr_stb <= 1'b0;
            rc_stb <= 1'b0;
            i2c_sda_out <= 1'b0;
            if (!lock_s || sp_cond) begin
                ist <= I_IDLE;
                i2c_sda_oe_n_out <= 1'b1;
            end else if (st_cond) begin
                ist <= I_ADDR;
                bcnt <= 4'h0;
                i2c_sda_oe_n_out <= 1'b1;
            end else if (rise) begin
                if (ist == I_ADDR || ist == I_WR || ist == I_RD) begin
                    sh   <= {sh[6:0], sda_s};
                    bcnt <= bcnt + 4'h1;
                end else if (ist == I_ACKR && sda_s) begin
                    ist <= I_IDLE;
                end
            end else if (fall) begin
                case (ist)
                    I_ADDR: if (bcnt == 4'h8) begin
                        if (sh[7:1] == `PSS_I2C_ADDR) begin
                            ist <= I_ACKA; rw <= sh[0]; i2c_sda_oe_n_out <= 1'b0;
                        end else begin
                            ist <= I_IDLE;
                        end
                    end
                    I_WR: if (bcnt == 4'h8) begin
                        ist <= I_ACKW; i2c_sda_oe_n_out <= 1'b0; first <= 1'b0;
                        if (first) begin
                            ptr <= sh;
                        end else begin
                            wr_stb <= 1'b1; wr_ptr <= ptr; wr_data <= sh; ptr <= ptr + 8'h01;
                        end
                    end
                    I_ACKW: begin
                        ist <= I_WR; bcnt <= 4'h0; i2c_sda_oe_n_out <= 1'b1;
                    end
                    I_ACKA, I_ACKR: begin
                        bcnt <= 4'h0;
                        if (ist == I_ACKA && !rw) begin
                            ist <= I_WR; first <= 1'b1; i2c_sda_oe_n_out <= 1'b1;
                        end else begin
                            ist <= I_RD; tx <= rdata; ptr <= ptr + 8'h01;
                            rc_stb <= is_st;
                            i2c_sda_oe_n_out <= rdata[7];
                        end
                    end
                    I_RD: if (bcnt == 4'h8) begin
                        ist <= I_ACKR; i2c_sda_oe_n_out <= 1'b1;
                    end else begin
                        tx <= {tx[6:0], 1'b0}; i2c_sda_oe_n_out <= tx[6];
                    end
                    default: ist <= I_IDLE;
                endcase
            end
        end
    end

    // ****************************
    // assertions
    // ****************************
    default clocking cb @(posedge clk_sys_in); endclocking
    default disable iff (!rst_n_in);
    sequence s_fault_entry;
        fstate == F_RUN ##1 fstate == F_OFF;
    endsequence
    sequence s_off_window;
        !outputs_enable_out [*8];
    endsequence
    irq_pull_low_a: assert property ((|fault_lat) |=> !interrupt_oe_n_out && !interrupt_n_out)
        else $error("latched fault without interrupt");
    scale_deep_sleep_a: assert property (dsl_s |=> !scaling_active_out)
        else $error("scaling in deep sleep");
    scale_disabled_a: assert property (!ctrl[`PSS_B_SEN] && !pin_s |=> !scaling_active_out)
        else $error("scaling while disabled");
    lockout_off_a: assert property (!lock_s |-> ##2 !outputs_enable_out)
        else $error("outputs on below lockout");
    fault_off_hold_a: assert property (s_fault_entry |-> ##1 s_off_window)
        else $error("outputs back too soon after fault");
    fault_exit_time_a: assert property ($fell(fstate == F_OFF) && $past(lock_s)
        |-> $past(foff_cnt) == 8'(`PSS_FOFF_TICKS - 1))
        else $error("fault retry left early");
    reset_drop_a: assert property (!rst_ok |=> !system_reset_n_out)
        else $error("reset not dropped");
    reset_delay_a: assert property ($rose(system_reset_n_out) |-> rst_cnt == rst_target
        && rst_cnt >= 8'(`PSS_RMIN_TICKS))
        else $error("reset released before delay");
    read_keep_a: assert property (rc_stb |=> ($past(fault_lat & live) & ~fault_lat) == 8'h00)
        else $error("status cleared while cause present");
endmodule
`default_nettype wire

// *** tb/pss_host.sv ***
/* i2c host model for the supply supervisor bench
   assumes the bench resolves sda as open drain with a pull-up */
`default_nettype none
`include "pss_regs.svh"
module pss_host (
    input  wire logic clk_sys_in,
    input  wire logic sda_in,
    output var  logic scl_out,
    output var  logic sda_low_out,
    output var  logic nak_out
);
    timeunit 1ns;
    timeprecision 1ns;
    initial begin
        scl_out = 1'b1;
        sda_low_out = 1'b0;
        nak_out = 1'b0;
    end
    // ****************************
    // bus cycles
    // ****************************
    task automatic wt;
        repeat (8) @(negedge clk_sys_in);
    endtask
    task automatic go(input logic s, input logic l);
        scl_out = s;
        sda_low_out = l;
        wt;
    endtask
    task automatic bitx(input logic v, output logic s);
        go(1'b0, ~v);
        go(1'b1, ~v);
        s = sda_in;
    endtask
    task automatic xb(input logic [7:0] b, input logic m, input logic c, output logic [7:0] r);
        logic a;
        for (int i = 7; i >= 0; i--) bitx(b[i], r[i]);
        bitx(m, a);
        if (c && a) nak_out = 1'b1;
    endtask
    task automatic start;
        go(1'b0, 1'b0);
        go(1'b1, 1'b0);
        go(1'b1, 1'b1);
        go(1'b0, 1'b1);
    endtask
    task automatic stop;
        go(1'b0, 1'b1);
        go(1'b1, 1'b1);
        go(1'b1, 1'b0);
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        logic [7:0] r;
        start;
        xb({`PSS_I2C_ADDR, 1'b0}, 1'b1, 1'b1, r);
        xb(a, 1'b1, 1'b1, r);
        xb(d, 1'b1, 1'b1, r);
        stop;
    endtask
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        logic [7:0] r;
        start;
        xb({`PSS_I2C_ADDR, 1'b0}, 1'b1, 1'b1, r);
        xb(a, 1'b1, 1'b1, r);
        start;
        xb({`PSS_I2C_ADDR, 1'b1}, 1'b1, 1'b1, r);
        xb(8'hff, 1'b1, 1'b0, d);
        stop;
    endtask
endmodule
`default_nettype wire

// *** tb/pss_supervisor_tb.sv ***
/* bench of the supply supervisor
   assumes pss_host as i2c master and a pull-up on sda */
`default_nettype none
`include "pss_regs.svh"
module pss_supervisor_tb;
    timeunit 1ns;
    timeprecision 1ns;
    localparam int TICK = 10;
    logic       clk, rst_n, lock, mon, input_overvoltage_threshold, temp, ssd, pin, slp, dslp, gp, scl, sda_low, nak;
    logic [4:0] ov, regulator_power_ok;
    logic       epg = 1'b0;
    logic [1:0] ldo = 2'h0;
    wire        stt, sda_o;
    logic [7:0] d;
    logic [6:0] tbl [8] = '{7'h04, 7'h45, 7'h01, 7'h53, 7'h07, 7'h37, 7'h48, 7'h28};
    wire        scal, oen, irq, irq_oe_n, rstn, xen, xen_oe_n, sda_oe_n;
    wire        sda = ~(sda_low | ~sda_oe_n);
    int         n_mismatch = 0, samples_checked = 0, n;
    pss_host u_host (.clk_sys_in(clk), .sda_in(sda), .scl_out(scl), .sda_low_out(sda_low), .nak_out(nak));
    pss_supervisor #(.TICK_CYCLES(TICK)) u_dut (.clk_sys_in(clk), .rst_n_in(rst_n), .i2c_scl_in(scl),
        .i2c_sda_in(sda), .i2c_sda_out(sda_o), .i2c_sda_oe_n_out(sda_oe_n), .above_lockout_in(lock),
        .below_monitor_in(mon), .above_overvoltage_in(input_overvoltage_threshold), .temp_warning_in(temp), .output_uv_in(5'h0),
        .output_ov_in(ov), .buck_current_limit_in(3'h0), .ldo_current_limit_in(ldo), .switch_cycle_in(1'b0),
        .soft_start_done_in(ssd), .regulator_power_ok_in(regulator_power_ok), .external_power_good_in(epg),
        .scaling_pin_in(pin), .sleep_state_in(slp), .deep_sleep_state_in(dslp), .gp_trigger_in(gp),
        .scaling_active_out(scal), .outputs_enable_out(oen), .startup_trigger_out(stt), .system_reset_n_out(rstn),
        .interrupt_n_out(irq), .interrupt_oe_n_out(irq_oe_n), .external_supply_enable_out(xen),
        .external_supply_enable_oe_n_out(xen_oe_n));
    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end
    // ****************************
    // tests
    // ****************************
    task automatic cyc(input int k);
        repeat (k) @(negedge clk);
    endtask
    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("wrong value t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic t_monitor;
        chk({oen, rstn, irq_oe_n, stt}, 4'b0010);
        u_host.rd(`PSS_MASK, d);
        chk(d, 8'hff);
        u_host.rd(8'h07, d);
        chk(d, 8'h00);
        u_host.rd(`PSS_FLAGS, d);
        chk(d, 8'h01);
        mon = 1'b0;
        cyc(6);
        chk(oen, 1'b1);
        input_overvoltage_threshold = 1'b1;
        u_host.rd(`PSS_FLAGS, d);
        chk({d, irq_oe_n}, 9'h005);
        input_overvoltage_threshold = 1'b0;
        lock = 1'b0;
        cyc(6);
        chk(oen, 1'b0);
        lock = 1'b1;
        cyc(6);
        $display("done monitor");
    endtask
    task automatic t_irq;
        u_host.wr(`PSS_MASK, 8'hfa);
        temp = 1'b1;
        cyc(6);
        chk({irq_oe_n, irq}, 2'b00);
        u_host.rd(`PSS_ST_A, d);
        cyc(6);
        chk({d, irq_oe_n}, 9'h008);
        temp = 1'b0;
        mon = 1'b1;
        cyc(6);
        chk(oen, 1'b1);
        u_host.rd(`PSS_ST_H, d);
        chk(d, 8'h00);
        u_host.rd(`PSS_ST_A, d);
        chk(d, 8'h01);
        mon = 1'b0;
        cyc(6);
        chk(irq_oe_n, 1'b0);
        u_host.rd(`PSS_ST_A, d);
        cyc(4);
        chk({d, irq_oe_n}, 9'h003);
        u_host.wr(`PSS_MASK, 8'hff);
        $display("done interrupt");
    endtask
    task automatic t_scale;
        foreach (tbl[i]) begin
            u_host.wr(`PSS_CTRL, {5'h00, tbl[i][2:0]});
            {dslp, slp, pin} = tbl[i][5:3];
            cyc(6);
            chk(scal, tbl[i][6]);
        end
        {dslp, slp, pin} = 3'b000;
        $display("done scaling");
    endtask
    task automatic t_reset_retry;
        u_host.wr(`PSS_CTRL, 8'h10);
        regulator_power_ok = 5'h1e;
        cyc(4);
        chk(rstn, 1'b0);
        regulator_power_ok = 5'h1f;
        for (n = 0; rstn !== 1'b1 && n < 1000; n++) cyc(1);
        chk(n >= 80 * TICK - 10 && n <= 80 * TICK + 15, 1'b1);
        ssd = 1'b1;
        ov = 5'h01;
        cyc(5);
        chk(oen, 1'b0);
        ov = 5'h00;
        for (n = 0; oen !== 1'b1 && n < 2500; n++) cyc(1);
        chk(n >= 200 * TICK - 20 && n <= 200 * TICK + 10, 1'b1);
        u_host.wr(`PSS_CTRL, 8'h08);
        ov = 5'h01;
        cyc(6);
        chk(oen, 1'b1);
        ov = 5'h00;
        $display("done reset and retry");
    endtask
    task automatic t_ext;
        u_host.wr(`PSS_EXT, 8'h50);
        gp = 1'b1;
        epg = 1'b1;
        ldo = 2'h1;
        cyc(5);
        chk({xen, xen_oe_n, stt}, 3'b101);
        u_host.wr(`PSS_EXT, 8'hd0);
        cyc(5);
        chk({xen, xen_oe_n}, 2'b01);
        u_host.rd(`PSS_FLAGS, d);
        chk(d, 8'h40);
        ldo = 2'h0;
        u_host.wr(`PSS_EXT, 8'h70);
        gp = 1'b0;
        cyc(30);
        chk({xen, xen_oe_n}, 2'b00);
        gp = 1'b1;
        cyc(30);
        chk(xen, 1'b0);
        cyc(30);
        chk(xen, 1'b1);
        u_host.wr(`PSS_EXT, 8'h08);
        cyc(5);
        chk(xen_oe_n, 1'b1);
        slp = 1'b1;
        cyc(5);
        chk(xen_oe_n, 1'b0);
        slp = 1'b0;
        $display("done external enable");
    endtask
    task automatic summarize;
        $display("checks %0d mismatches %0d", samples_checked, n_mismatch);
        if (n_mismatch == 0 && samples_checked > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask
    initial begin
        {rst_n, lock, mon, input_overvoltage_threshold, temp, ssd, pin, slp, dslp, gp, ov, regulator_power_ok} = {10'h180, 5'h00, 5'h1f};
        cyc(20);
        rst_n = 1'b1;
        cyc(3);
        t_monitor;
        t_irq;
        t_scale;
        t_reset_retry;
        t_ext;
        chk({nak, sda_o}, 2'b00);
        summarize;
    end
    initial begin
        #6000000;
        n_mismatch++;
        summarize;
    end
endmodule
`default_nettype wire
